//--- src/mrs_defs.vh
// Constants for the reset source sequencer: sequencer states, cause codes,
// cause-register bit positions and reset values.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef MRS_DEFS_VH
`define MRS_DEFS_VH

// Low-speed oscillator cycles counted before the internal reset is released
`define MRS_RELEASE_TICKS 6'd32
`define MRS_TICK_W 6

// Sequencer states
`define MRS_ST_RUN 2'b00
`define MRS_ST_HOLD 2'b01
`define MRS_ST_COUNT 2'b10
`define MRS_ST_HALT 2'b11

// Reset cause codes
`define MRS_CAUSE_POR 3'h0
`define MRS_CAUSE_MON0 3'h1
`define MRS_CAUSE_PIN 3'h2
`define MRS_CAUSE_OSC 3'h3
`define MRS_CAUSE_MON1 3'h4
`define MRS_CAUSE_MON2 3'h5
`define MRS_CAUSE_WDT 3'h6
`define MRS_CAUSE_SOFT 3'h7

// Bit positions in the reset cause register
`define MRS_BIT_CWR 0
`define MRS_BIT_HWR 1
`define MRS_BIT_SWR 2
`define MRS_BIT_WDR 3
`define MRS_BIT_LVD1 4
`define MRS_BIT_LVD2 5
`define MRS_BIT_OSD 6
`define MRS_CAUSE_W 7

// Cause register after a power-on of the sequencer (cold start, no flag)
`define MRS_CAUSE_RST 7'h00

// Synchroniser reset values: {pin_b, mon0_low, mon1_low, mon2_low, osc_stop, strap}
`define MRS_SYNC_W 6
`define MRS_SYNC_RST 6'h30

// Processor-mode bits after async reset, before the strap is captured
`define MRS_MODE_RST 2'h0

`endif

//--- src/mrs_tick_counter.v
// Counts rising edges of the low-speed on-chip oscillator clock while enabled
// and flags when the programmed number of edges has been seen.
// Assumes the oscillator clock is asynchronous to CLOCK and much slower.
`timescale 1ns/1ps
`include "mrs_defs.vh"

module mrs_tick_counter #(
   parameter TICK_W = `MRS_TICK_W,
   parameter [`MRS_TICK_W-1:0] TICKS = `MRS_RELEASE_TICKS
) (
   input wire clk,
   input wire rst_b,
   input wire ce,
   input wire osc_clk,
   input wire run,
   output reg done
);

   reg sync1;
   reg sync2;
   reg sync3;
   reg [TICK_W-1:0] cnt;
   wire tick_edge;

   assign tick_edge = sync2 & ~sync3;

   // Two-stage synchroniser, third stage only for edge detection
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else if (ce) begin
         sync1 <= osc_clk;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Count restarts from zero whenever run drops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= {TICK_W{1'b0}};
         done <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt <= {TICK_W{1'b0}};
            done <= 1'b0;
         end else if (tick_edge && !done) begin
            cnt <= cnt + 1'b1;
            done <= (cnt == TICKS - 1'b1);
         end
      end
   end

endmodule // mrs_tick_counter

//--- src/mrs_reset_sequencer.v
// Reset sequencer: merges all reset sources into the internal reset, times
// its release, records the reset cause and keeps the processor-mode bits through the milder resets.
// Assumes analog monitors, oscillator-stop detector and watchdog deliver only
// their trigger levels or pulses; RST_B is the power-on of this logic.
`timescale 1ns/1ps
`include "mrs_defs.vh"

module mrs_reset_sequencer #(
   parameter TICK_W = `MRS_TICK_W,
   parameter [`MRS_TICK_W-1:0] RELEASE_TICKS = `MRS_RELEASE_TICKS
) (
   input wire CLOCK,
   input wire RST_B,
   input wire CE,
   input wire RESET_PIN_B,
   input wire OSC_LS_CLK,
   input wire MON0_LOW,
   input wire MON1_LOW,
   input wire MON2_LOW,
   input wire OSC_STOP_DET,
   input wire MODE_STRAP,
   input wire MON0_RESET_EN,
   input wire MON1_RESET_SEL,
   input wire MON2_RESET_SEL,
   input wire WDT_RESET_SEL,
   input wire OSC_STOP_ACTION,
   input wire WDT_UNDERFLOW,
   input wire SOFT_RESET_WR,
   input wire CWR_WR,
   input wire CWR_WDATA,
   input wire OSC_STOP_CAUSE_FLAG_WR,
   input wire OSC_STOP_CAUSE_FLAG_WDATA,
   input wire MODE_WR,
   input wire [1:0] MODE_WDATA,
   input wire CLK_SEL_CLR,
   output reg INT_RESET_B,
   output reg VECTOR_FETCH,
   output reg CPU_HALT,
   output reg CLK_LS_DIV8_SEL,
   output reg PIN_RESET_CAUSE_FLAG,
   output reg COLD_WARM_START_FLAG,
   output reg OSC_STOP_CAUSE_FLAG,
   output reg MONITOR1_CAUSE_FLAG,
   output reg MONITOR2_CAUSE_FLAG,
   output reg WATCHDOG_CAUSE_FLAG,
   output reg SOFT_RESET_CAUSE_FLAG,
   output reg [1:0] PROC_MODE
);

   // Asynchronous inputs and their synchronised copies
   wire [`MRS_SYNC_W-1:0] async_in;
   reg [`MRS_SYNC_W-1:0] sync1;
   reg [`MRS_SYNC_W-1:0] sync2;
   wire pin_b_s;
   wire mon0_low_s;
   wire mon1_low_s;
   wire mon2_low_s;
   wire osc_stop_s;
   wire strap_s;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] cause;
   reg [2:0] next_cause;
   reg por_pending;
   reg [`MRS_CAUSE_W-1:0] flags;
   reg [`MRS_CAUSE_W-1:0] next_flags;
   reg [1:0] next_mode;
   reg release_now;
   reg take_reset;
   localparam [`MRS_SYNC_W-1:0] sync_init = `MRS_SYNC_RST;

   wire src_por;
   wire src_mon0;
   wire src_pin;
   wire src_osc;
   wire src_mon1;
   wire src_mon2;
   wire src_wdt;
   wire src_soft;
   wire any_src;
   wire count_done;
   wire mode_keep;

   assign async_in = {RESET_PIN_B, MON0_LOW, MON1_LOW, MON2_LOW, OSC_STOP_DET, MODE_STRAP};

   genvar gi;
   generate
      for (gi = 0; gi < `MRS_SYNC_W; gi = gi + 1) begin : g_sync
         always @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
               sync1[gi] <= sync_init[gi];
               sync2[gi] <= sync_init[gi];
            end else if (CE) begin
               sync1[gi] <= async_in[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   assign pin_b_s = sync2[5];
   assign mon0_low_s = sync2[4];
   assign mon1_low_s = sync2[3];
   assign mon2_low_s = sync2[2];
   assign osc_stop_s = sync2[1];
   assign strap_s = sync2[0];

   // Reset requests; the halted state listens to pin and monitor 0 only
   assign src_por = por_pending & mon0_low_s;
   assign src_mon0 = mon0_low_s & MON0_RESET_EN;
   assign src_pin = ~pin_b_s;
   assign src_osc = osc_stop_s & ~OSC_STOP_ACTION & (state != `MRS_ST_HALT);
   assign src_mon1 = mon1_low_s & MON1_RESET_SEL & (state != `MRS_ST_HALT);
   assign src_mon2 = mon2_low_s & MON2_RESET_SEL & (state != `MRS_ST_HALT);
   assign src_wdt = WDT_UNDERFLOW & WDT_RESET_SEL & (state != `MRS_ST_HALT);
   assign src_soft = SOFT_RESET_WR & (state != `MRS_ST_HALT);
   assign any_src = src_por | src_mon0 | src_pin | src_osc | src_mon1 | src_mon2 |
                    src_wdt | src_soft;

   // Processor mode kept by the milder resets
   assign mode_keep = (cause != `MRS_CAUSE_POR) && (cause != `MRS_CAUSE_MON0) &&
                      (cause != `MRS_CAUSE_PIN);

   mrs_tick_counter #(
      .TICK_W(TICK_W),
      .TICKS(RELEASE_TICKS)
   ) u_ticks (
      .clk(CLOCK),
      .rst_b(RST_B),
      .ce(CE),
      .osc_clk(OSC_LS_CLK),
      .run(state == `MRS_ST_COUNT),
      .done(count_done)
   );

   // Highest-priority cause among simultaneous sources
   always @* begin
      if (src_por)
         next_cause = `MRS_CAUSE_POR;
      else if (src_mon0)
         next_cause = `MRS_CAUSE_MON0;
      else if (src_pin)
         next_cause = `MRS_CAUSE_PIN;
      else if (src_osc)
         next_cause = `MRS_CAUSE_OSC;
      else if (src_mon1)
         next_cause = `MRS_CAUSE_MON1;
      else if (src_mon2)
         next_cause = `MRS_CAUSE_MON2;
      else if (src_wdt)
         next_cause = `MRS_CAUSE_WDT;
      else
         next_cause = `MRS_CAUSE_SOFT;
   end

   // Sequencer transitions
   always @* begin
      next_state = state;
      release_now = 1'b0;
      take_reset = any_src;
      case (state)
         `MRS_ST_RUN: begin
            if (any_src)
               next_state = `MRS_ST_HOLD;
         end
         `MRS_ST_HOLD: begin
            if (any_src)
               next_state = `MRS_ST_HOLD;
            else if (cause == `MRS_CAUSE_PIN) begin
               next_state = `MRS_ST_RUN;
               release_now = 1'b1;
            end else if (cause == `MRS_CAUSE_OSC)
               next_state = `MRS_ST_HALT;
            else
               next_state = `MRS_ST_COUNT;
         end
         `MRS_ST_COUNT: begin
            if (any_src)
               next_state = `MRS_ST_HOLD;
            else if (count_done) begin
               next_state = `MRS_ST_RUN;
               release_now = 1'b1;
            end
         end
         `MRS_ST_HALT: begin
            if (any_src)
               next_state = `MRS_ST_HOLD;
         end
         default: begin
            next_state = `MRS_ST_HOLD;
            take_reset = 1'b1;
         end
      endcase
   end

   // Cause register: a reset taken in the same cycle beats any software write
   always @* begin
      next_flags = flags;
      if (take_reset) begin
         next_flags[`MRS_BIT_HWR] = 1'b0;
         next_flags[`MRS_BIT_SWR] = 1'b0;
         next_flags[`MRS_BIT_WDR] = 1'b0;
         next_flags[`MRS_BIT_LVD1] = 1'b0;
         next_flags[`MRS_BIT_LVD2] = 1'b0;
         next_flags[`MRS_BIT_OSD] = 1'b0;
         case (next_cause)
            `MRS_CAUSE_POR: begin
               next_flags[`MRS_BIT_CWR] = 1'b0;
            end
            `MRS_CAUSE_MON0: begin
               next_flags[`MRS_BIT_CWR] = 1'b0;
            end
            `MRS_CAUSE_PIN: begin
               next_flags[`MRS_BIT_HWR] = 1'b1;
               next_flags[`MRS_BIT_OSD] = flags[`MRS_BIT_OSD];
            end
            `MRS_CAUSE_OSC: begin
               next_flags[`MRS_BIT_OSD] = 1'b1;
            end
            `MRS_CAUSE_MON1: begin
               next_flags[`MRS_BIT_LVD1] = 1'b1;
            end
            `MRS_CAUSE_MON2: begin
               next_flags[`MRS_BIT_LVD2] = 1'b1;
            end
            `MRS_CAUSE_WDT: begin
               next_flags[`MRS_BIT_WDR] = 1'b1;
            end
            default: begin
               next_flags[`MRS_BIT_SWR] = 1'b1;
            end
         endcase
      end else begin
         if (CWR_WR && CWR_WDATA)
            next_flags[`MRS_BIT_CWR] = 1'b1;
         if (OSC_STOP_CAUSE_FLAG_WR && !OSC_STOP_CAUSE_FLAG_WDATA)
            next_flags[`MRS_BIT_OSD] = 1'b0;
      end
   end

   // Processor mode: strap on the harsh resets, kept otherwise
   always @* begin
      next_mode = PROC_MODE;
      if (release_now && !mode_keep)
         next_mode = {strap_s, strap_s};
      else if (release_now)
         next_mode = PROC_MODE;
      else if (MODE_WR && state == `MRS_ST_RUN && !any_src)
         next_mode = MODE_WDATA;
   end

   // Sequencer and cause state
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         state <= `MRS_ST_HOLD;
         cause <= `MRS_CAUSE_POR;
         por_pending <= 1'b1;
         flags <= `MRS_CAUSE_RST;
         PROC_MODE <= `MRS_MODE_RST;
      end else if (CE) begin
         state <= next_state;
         if (take_reset)
            cause <= next_cause;
         if (release_now)
            por_pending <= 1'b0;
         flags <= next_flags;
         PROC_MODE <= next_mode;
      end
   end

   // Registered outputs: internal reset, vector fetch, CPU halt and clock select
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         INT_RESET_B <= 1'b0;
         VECTOR_FETCH <= 1'b0;
         CPU_HALT <= 1'b0;
         CLK_LS_DIV8_SEL <= 1'b1;
      end else if (CE) begin
         INT_RESET_B <= (next_state == `MRS_ST_RUN);
         VECTOR_FETCH <= release_now;
         CPU_HALT <= (next_state == `MRS_ST_HALT);
         if (next_state != `MRS_ST_RUN)
            CLK_LS_DIV8_SEL <= 1'b1;
         else if (CLK_SEL_CLR && !release_now)
            CLK_LS_DIV8_SEL <= 1'b0;
      end
   end

   // Cause flags mirrored to output flip-flops
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         PIN_RESET_CAUSE_FLAG <= 1'b0;
         COLD_WARM_START_FLAG <= 1'b0;
         OSC_STOP_CAUSE_FLAG <= 1'b0;
         MONITOR1_CAUSE_FLAG <= 1'b0;
         MONITOR2_CAUSE_FLAG <= 1'b0;
         WATCHDOG_CAUSE_FLAG <= 1'b0;
         SOFT_RESET_CAUSE_FLAG <= 1'b0;
      end else if (CE) begin
         PIN_RESET_CAUSE_FLAG <= next_flags[`MRS_BIT_HWR];
         COLD_WARM_START_FLAG <= next_flags[`MRS_BIT_CWR];
         OSC_STOP_CAUSE_FLAG <= next_flags[`MRS_BIT_OSD];
         MONITOR1_CAUSE_FLAG <= next_flags[`MRS_BIT_LVD1];
         MONITOR2_CAUSE_FLAG <= next_flags[`MRS_BIT_LVD2];
         WATCHDOG_CAUSE_FLAG <= next_flags[`MRS_BIT_WDR];
         SOFT_RESET_CAUSE_FLAG <= next_flags[`MRS_BIT_SWR];
      end
   end

endmodule // mrs_reset_sequencer

//--- dv/mrs_chk.sv
// Port-level checker for the reset sequencer.
// Assumes CE is held high and RST_B is the power-on of the block.
`timescale 1ns/1ps
module mrs_chk (
   input wire CLOCK,
   input wire RST_B,
   input wire RESET_PIN_B,
   input wire MON0_LOW,
   input wire CWR_WR,
   input wire CWR_WDATA,
   input wire OSC_STOP_CAUSE_FLAG_WR,
   input wire OSC_STOP_CAUSE_FLAG_WDATA,
   input wire INT_RESET_B,
   input wire VECTOR_FETCH,
   input wire CPU_HALT,
   input wire CLK_LS_DIV8_SEL,
   input wire PIN_RESET_CAUSE_FLAG,
   input wire COLD_WARM_START_FLAG,
   input wire OSC_STOP_CAUSE_FLAG,
   input wire MONITOR1_CAUSE_FLAG,
   input wire MONITOR2_CAUSE_FLAG,
   input wire WATCHDOG_CAUSE_FLAG,
   input wire SOFT_RESET_CAUSE_FLAG,
   input wire [1:0] PROC_MODE
);
   wire mild = SOFT_RESET_CAUSE_FLAG | WATCHDOG_CAUSE_FLAG | MONITOR1_CAUSE_FLAG
      | MONITOR2_CAUSE_FLAG;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   pin_low_hold_a: assert property (!RESET_PIN_B [*3] |=> !INT_RESET_B)
      else $error("pin low but internal reset released");
   mon0_hold_a: assert property (MON0_LOW [*3] |=> !INT_RESET_B)
      else $error("supply low but internal reset released");
   vector_pulse_a: assert property (VECTOR_FETCH |->
      (INT_RESET_B && !$past(INT_RESET_B)) ##1 !VECTOR_FETCH)
      else $error("vector fetch not a single pulse at release");
   clk_sel_a: assert property ($rose(INT_RESET_B) |-> CLK_LS_DIV8_SEL)
      else $error("slow clock not selected at release");
   one_cause_a: assert property ($onehot0({PIN_RESET_CAUSE_FLAG, mild ?
      {SOFT_RESET_CAUSE_FLAG, WATCHDOG_CAUSE_FLAG, MONITOR1_CAUSE_FLAG,
      MONITOR2_CAUSE_FLAG} : 4'h0}))
      else $error("more than one cause flag set");
   halt_state_a: assert property (CPU_HALT |-> !INT_RESET_B && OSC_STOP_CAUSE_FLAG)
      else $error("halt without reset or stop flag");
   halt_exit_a: assert property ($fell(CPU_HALT) |-> !$past(RESET_PIN_B, 2)
      || !$past(RESET_PIN_B, 3) || $past(MON0_LOW, 2) || $past(MON0_LOW, 3))
      else $error("halt left without pin or supply reset");
   mode_keep_a: assert property (!INT_RESET_B && mild |=> $stable(PROC_MODE))
      else $error("mode bits changed in a mild reset");
   cwr_set_a: assert property ($rose(COLD_WARM_START_FLAG) |-> $past(CWR_WR)
      && $past(CWR_WDATA))
      else $error("warm flag set without a write of one");
   osc_stop_cause_flag_clear_a: assert property ($fell(OSC_STOP_CAUSE_FLAG) |-> !INT_RESET_B
      || ($past(OSC_STOP_CAUSE_FLAG_WR) && !$past(OSC_STOP_CAUSE_FLAG_WDATA)))
      else $error("stop flag cleared without cause");
   release_c: cover property (VECTOR_FETCH);
   halt_c: cover property ($fell(CPU_HALT));
   warm_c: cover property ($rose(COLD_WARM_START_FLAG));
endmodule // mrs_chk

bind mrs_reset_sequencer mrs_chk chk (.*);

//--- dv/mrs_ext_supply.sv
// External reset circuit and supply: pull-up pin, supply monitor 0, slow oscillator.
// Assumes the bench calls its tasks; drives change just after a CLOCK edge.
`timescale 1ns/1ps
module mrs_ext_supply #(
   parameter OSC_HALF = 20,
   parameter SETTLE = 60
) (
   input wire clk,
   output reg pin_b,
   output reg mon0_low,
   output reg osc_clk
);
   initial begin
      pin_b = 1'h1;
      mon0_low = 1'h1;
      osc_clk = 1'h0;
      repeat (SETTLE) @(posedge clk);
      #1 mon0_low = 1'h0;
   end
   always #(OSC_HALF) osc_clk = ~osc_clk;
   // Pin held low for the oscillator interval, then back to the pull-up
   task pin_reset(input integer ticks);
      begin
         @(posedge clk);
         #1 pin_b = 1'h0;
         repeat (ticks) @(posedge osc_clk);
         @(posedge clk);
         #1 pin_b = 1'h1;
      end
   endtask
   task supply_dip(input integer cyc);
      begin
         @(posedge clk);
         #1 mon0_low = 1'h1;
         repeat (cyc) @(posedge clk);
         #1 mon0_low = 1'h0;
      end
   endtask
   // Power-up with the pin held low through supply settling and the interval
   task power_up(input integer ticks);
      begin
         @(posedge clk);
         #1 pin_b = 1'h0;
         mon0_low = 1'h1;
         repeat (SETTLE) @(posedge clk);
         #1 mon0_low = 1'h0;
         repeat (ticks) @(posedge osc_clk);
         @(posedge clk);
         #1 pin_b = 1'h1;
      end
   endtask
endmodule // mrs_ext_supply

//--- dv/test_mrs_reset_sequencer.sv
// Self-checking bench for the reset sequencer with a flag and mode model.
// Assumes a 40 ns slow oscillator and a release count of four ticks.
`timescale 1ns/1ps
`include "mrs_defs.vh"
module test_mrs_reset_sequencer;
   localparam [5:0] TK = 6'h04;
   localparam LO = (TK - 1) * 8;
   localparam HI = (TK + 2) * 8 + 8;
   reg CLOCK = 1'h0, RST_B = 1'h0, MODE_STRAP = 1'h0, MON1_LOW = 1'h0, MON2_LOW = 1'h0;
   reg OSC_STOP_DET = 1'h0, MON1_RESET_SEL = 1'h0, MON2_RESET_SEL = 1'h0, WDT_RESET_SEL = 1'h0;
   reg OSC_STOP_ACTION = 1'h1, WDT_UNDERFLOW = 1'h0, SOFT_RESET_WR = 1'h0, CWR_WR = 1'h0;
   reg CWR_WDATA = 1'h0, OSC_STOP_CAUSE_FLAG_WR = 1'h0, OSC_STOP_CAUSE_FLAG_WDATA = 1'h0, MODE_WR = 1'h0, CLK_SEL_CLR = 1'h0;
   reg [1:0] MODE_WDATA = 2'h0;
   wire CE = 1'h1;
   wire MON0_RESET_EN = 1'h1;
   wire RESET_PIN_B, OSC_LS_CLK, MON0_LOW, INT_RESET_B, VECTOR_FETCH, CPU_HALT, CLK_LS_DIV8_SEL;
   wire PIN_RESET_CAUSE_FLAG, COLD_WARM_START_FLAG, OSC_STOP_CAUSE_FLAG, MONITOR1_CAUSE_FLAG;
   wire MONITOR2_CAUSE_FLAG, WATCHDOG_CAUSE_FLAG, SOFT_RESET_CAUSE_FLAG;
   wire [1:0] PROC_MODE;
   wire [6:0] flg = {OSC_STOP_CAUSE_FLAG, MONITOR2_CAUSE_FLAG, MONITOR1_CAUSE_FLAG,
      WATCHDOG_CAUSE_FLAG, SOFT_RESET_CAUSE_FLAG, PIN_RESET_CAUSE_FLAG, COLD_WARM_START_FLAG};
   reg [6:0] ef = 7'h00;
   reg [1:0] em = 2'h0;
   integer err_total = 0, check_count = 0, n, s;
   mrs_reset_sequencer #(.RELEASE_TICKS(TK)) uut (.*);
   mrs_ext_supply ext (.clk(CLOCK), .pin_b(RESET_PIN_B), .mon0_low(MON0_LOW),
      .osc_clk(OSC_LS_CLK));
   always #2.5 CLOCK = ~CLOCK;
   task results;
      begin
         if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Cold resets clear all; pin keeps warm and stop flags; others keep warm only
   task model(input integer b);
      begin
         if (b < 0)
            ef = 7'h00;
         else if (b == `MRS_BIT_HWR)
            ef = ef & 7'h41;
         else
            ef = ef & 7'h01;
         if (b >= 0)
            ef[b] = 1'h1;
         if (b <= `MRS_BIT_HWR)
            em = {2{MODE_STRAP}};
      end
   endtask
   task chk_bit(input a, input e);
      begin
         check_count = check_count + 1;
         if (a !== e) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: output %b, want %b", $time, a, e);
         end
      end
   endtask
   task chk_flags;
      begin
         check_count = check_count + 1;
         if ({flg, PROC_MODE} !== {ef, em}) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: flags %h, want %h", $time, {flg, PROC_MODE}, {ef, em});
         end
      end
   endtask
   task step(input integer k);
      begin
         repeat (k) @(posedge CLOCK);
         #1;
      end
   endtask
   task rel;
      begin
         n = 0;
         while (INT_RESET_B !== 1'h1 && n < 500) begin
            step(1);
            n = n + 1;
         end
         chk_bit(VECTOR_FETCH, 1'h1);
         chk_bit(CLK_LS_DIV8_SEL, 1'h1);
      end
   endtask
   task src(input integer k, input v);
      case (k)
         0: SOFT_RESET_WR = v;
         1: WDT_UNDERFLOW = v;
         2: MON1_LOW = v;
         default: MON2_LOW = v;
      endcase
   endtask
   initial begin
      s = $urandom(15);
      step(4);
      RST_B = 1'h1;
      chk_bit(INT_RESET_B, 1'h0);
      wait (MON0_LOW === 1'h0);
      rel;
      chk_bit(n >= LO && n <= HI, 1'h1);
      model(-1);
      chk_flags;
      CWR_WDATA = 1'h1;
      CWR_WR = 1'h1;
      OSC_STOP_CAUSE_FLAG_WDATA = 1'h1;
      OSC_STOP_CAUSE_FLAG_WR = 1'h1;
      CLK_SEL_CLR = 1'h1;
      step(1);
      CWR_WR = 1'h0;
      OSC_STOP_CAUSE_FLAG_WR = 1'h0;
      CLK_SEL_CLR = 1'h0;
      step(1);
      ef[`MRS_BIT_CWR] = 1'h1;
      chk_flags;
      chk_bit(CLK_LS_DIV8_SEL, 1'h0);
      for (s = 0; s < 4; s = s + 1) begin
         n = $urandom;
         MODE_STRAP = n[0];
         MODE_WDATA = n[2:1];
         MODE_WR = 1'h1;
         step(1);
         MODE_WR = 1'h0;
         em = MODE_WDATA;
         {MON1_RESET_SEL, MON2_RESET_SEL, WDT_RESET_SEL} = 3'h0;
         if (s > 0) begin
            src(s, 1'h1);
            step(8);
            src(s, 1'h0);
            step(8);
            chk_bit(INT_RESET_B, 1'h1);
         end
         {MON1_RESET_SEL, MON2_RESET_SEL, WDT_RESET_SEL} = 3'h7;
         src(s, 1'h1);
         step(1);
         if (s < 2)
            src(s, 1'h0);
         step(5);
         src(s, 1'h0);
         if (s < 2) begin
            step(16);
            src(s, 1'h1);
            step(1);
            src(s, 1'h0);
         end
         rel;
         chk_bit(n >= LO && n <= HI, 1'h1);
         model(`MRS_BIT_SWR + s);
         chk_flags;
      end
      OSC_STOP_ACTION = 1'h0;
      OSC_STOP_DET = 1'h1;
      step(8);
      OSC_STOP_DET = 1'h0;
      step(8);
      SOFT_RESET_WR = 1'h1;
      step(1);
      SOFT_RESET_WR = 1'h0;
      step(8);
      model(`MRS_BIT_OSD);
      chk_flags;
      chk_bit(CPU_HALT, 1'h1);
      chk_bit(INT_RESET_B, 1'h0);
      MODE_STRAP = ~MODE_STRAP;
      ext.pin_reset(TK);
      rel;
      chk_bit(n >= 3 && n <= 4, 1'h1);
      chk_bit(CPU_HALT, 1'h0);
      model(`MRS_BIT_HWR);
      chk_flags;
      OSC_STOP_CAUSE_FLAG_WR = 1'h1;
      OSC_STOP_CAUSE_FLAG_WDATA = 1'h1;
      step(1);
      chk_flags;
      OSC_STOP_CAUSE_FLAG_WDATA = 1'h0;
      step(1);
      OSC_STOP_CAUSE_FLAG_WR = 1'h0;
      ef[`MRS_BIT_OSD] = 1'h0;
      chk_flags;
      OSC_STOP_DET = 1'h1;
      step(8);
      OSC_STOP_DET = 1'h0;
      step(8);
      model(`MRS_BIT_OSD);
      chk_flags;
      chk_bit(CPU_HALT, 1'h1);
      ext.supply_dip(10);
      rel;
      chk_bit(n >= LO && n <= HI, 1'h1);
      chk_bit(CPU_HALT, 1'h0);
      model(-1);
      chk_flags;
      RST_B = 1'h0;
      step(1);
      ef = 7'h00;
      em = 2'h0;
      chk_flags;
      fork
         ext.power_up(TK);
         begin
            step(3);
            RST_B = 1'h1;
            step(2);
            chk_bit(INT_RESET_B, 1'h0);
         end
      join
      chk_bit(INT_RESET_B, 1'h0);
      rel;
      chk_bit(n >= 3 && n <= 4, 1'h1);
      model(`MRS_BIT_HWR);
      chk_flags;
      results;
   end
   initial begin
      #20000;
      err_total = err_total + 1;
      results;
   end
endmodule // test_mrs_reset_sequencer
